// ==== verilog/sdf_sinc3_decimator.sv ====
`timescale 1ns/100ps
`include "sdf_consts.svh"

module sdf_sinc3_decimator (
  input  wire logic              ref_clk_i,
  input  wire logic              reset_i,
  input  wire logic              modulator_bitstream_i,
  output logic                   modulator_clock_o,
  output sdf_pkg::sdf_word_t     sample_o,
  output logic                   sample_valid_o
);
  import sdf_pkg::*;

  // ----------------------------------------------------------------------
  // Modulator clock generation
  // ----------------------------------------------------------------------
  logic [2:0] div_q;
  logic [2:0] div_d;
  logic       mclk_q;
  logic       mclk_d;
  wire        half_done;
  wire        mclk_fall;
  wire        mclk_rise;

  // Divide by ten: 10 MHz modulator clock, framing the bitstream
  assign half_done = (div_q == (`SDF_MCLK_HALF + 3'h2));
  assign div_d     = half_done ? `SDF_DIV_RST : div_q + 3'h1;
  assign mclk_d    = half_done ? ~mclk_q : mclk_q;
  assign mclk_fall = half_done & mclk_q;
  assign mclk_rise = half_done & ~mclk_q;

  // Divider registers
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      div_q  <= `SDF_DIV_RST;
      mclk_q <= 1'b0;
    end else begin
      div_q  <= div_d;
      mclk_q <= mclk_d;
    end
  end

  // ----------------------------------------------------------------------
  // Bit capture and integrators
  // ----------------------------------------------------------------------
  logic     filter_bit_input_q;
  sdf_acc_t integrator_stage_one_q;
  sdf_acc_t integrator_stage_two_q;
  sdf_acc_t integrator_stage_three_q;
  sdf_acc_t bit_value;

  // Bit sampled as modulator clock falls, mid data eye
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      filter_bit_input_q <= 1'b0;
    end else if (mclk_fall) begin
      filter_bit_input_q <= modulator_bitstream_i;
    end
  end

  // Received bit widened to an input value of 0 or 1
  assign bit_value = {{(`SDF_ACC_W-1){1'b0}}, filter_bit_input_q};

  // Integrators advance on every modulator rising edge
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      integrator_stage_one_q   <= `SDF_ACC_RST;
      integrator_stage_two_q   <= `SDF_ACC_RST;
      integrator_stage_three_q <= `SDF_ACC_RST;
    end else if (mclk_rise) begin
      integrator_stage_one_q   <= integrator_stage_one_q + bit_value;
      integrator_stage_two_q   <= integrator_stage_two_q
                                  + integrator_stage_one_q;
      integrator_stage_three_q <= integrator_stage_three_q
                                  + integrator_stage_two_q;
    end
  end

  // ----------------------------------------------------------------------
  // Decimation counter and word clock
  // ----------------------------------------------------------------------
  sdf_cnt_t word_count_q;
  logic     word_clk_q;
  wire      word_clk;
  wire      word_rise;

  // Counter steps on each modulator falling edge, wraps freely
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      word_count_q <= `SDF_CNT_RST;
    end else if (mclk_fall) begin
      word_count_q <= word_count_q + 8'h01;
    end
  end

  // Word clock is the counter MSB; rising edge detected here
  assign word_clk  = word_count_q[`SDF_WORD_BIT];
  assign word_rise = word_clk & ~word_clk_q;

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      word_clk_q <= 1'b0;
    end else begin
      word_clk_q <= word_clk;
    end
  end

  // ----------------------------------------------------------------------
  // Differentiators and output register
  // ----------------------------------------------------------------------
  sdf_acc_t integrator_three_saved_q;
  sdf_acc_t comb_stage_one_q;
  sdf_acc_t comb_stage_two_q;
  sdf_acc_t comb_stage_three_q;
  sdf_acc_t comb_one_delay_q;
  sdf_acc_t comb_two_delay_q;
  sdf_word_t sample_q;
  logic     sample_valid_q;

  // Comb cascade runs once per word clock rising edge
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      integrator_three_saved_q <= `SDF_ACC_RST;
      comb_one_delay_q         <= `SDF_ACC_RST;
      comb_two_delay_q         <= `SDF_ACC_RST;
      comb_stage_one_q         <= `SDF_ACC_RST;
      comb_stage_two_q         <= `SDF_ACC_RST;
      comb_stage_three_q       <= `SDF_ACC_RST;
    end else if (word_rise) begin
      comb_stage_one_q <= integrator_stage_three_q
                          - integrator_three_saved_q;
      integrator_three_saved_q <= integrator_stage_three_q;
      comb_stage_two_q <= comb_stage_one_q - comb_one_delay_q;
      comb_one_delay_q <= comb_stage_one_q;
      comb_stage_three_q <= comb_stage_two_q - comb_two_delay_q;
      comb_two_delay_q   <= comb_stage_two_q;
    end
  end

  // Output word loads old comb three value, as in the reference
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      sample_q       <= `SDF_OUT_RST;
      sample_valid_q <= 1'b0;
    end else begin
      sample_valid_q <= word_rise;
      if (word_rise) begin
        sample_q <= comb_stage_three_q[`SDF_OUT_MSB:`SDF_OUT_LSB];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign modulator_clock_o = mclk_q;
  assign sample_o          = sample_q;
  assign sample_valid_o    = sample_valid_q;

endmodule // sdf_sinc3_decimator

// ==== verilog/sdf_consts.svh ====
`ifndef SDF_CONSTS_SVH
`define SDF_CONSTS_SVH

// ----------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------
`define SDF_ACC_W        24
`define SDF_CNT_W        8
`define SDF_OUT_W        16

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define SDF_WORD_BIT     7
`define SDF_OUT_MSB      23
`define SDF_OUT_LSB      8

// ----------------------------------------------------------------------
// Reset values and modulator clock divider
// ----------------------------------------------------------------------
`define SDF_ACC_RST      24'h000000
`define SDF_CNT_RST      8'h00
`define SDF_OUT_RST      16'h0000
`define SDF_MCLK_HALF    3'h2
`define SDF_DIV_RST      3'h0

`endif

// ==== verilog/sdf_pkg.sv ====
package sdf_pkg;
  `include "sdf_consts.svh"

  typedef logic [`SDF_ACC_W-1:0] sdf_acc_t;
  typedef logic [`SDF_CNT_W-1:0] sdf_cnt_t;
  typedef logic [`SDF_OUT_W-1:0] sdf_word_t;
endpackage

// ==== verif/sdf_mod_model.sv ====
`timescale 1ns/100ps
// Ones-density modulator, new bit just after each clock rise
module sdf_mod_model (
  input  wire logic       ref_clk_i,
  input  wire logic       modulator_clock_i,
  input  wire logic [7:0] dens_i,
  input  wire logic [7:0] rnd_i,
  output logic            modulator_bitstream_o
);
  logic clk_q = 1'b0;
  initial modulator_bitstream_o = 1'b0;
  // Data framed by the supplied clock, high in dens_i of 256
  always @(posedge ref_clk_i) begin
    clk_q <= modulator_clock_i;
    if (modulator_clock_i && !clk_q) begin
      modulator_bitstream_o <= rnd_i < dens_i;
    end
  end
endmodule // sdf_mod_model

// ==== verif/sdf_sinc3_decimator_sva.sv ====
`timescale 1ns/100ps
module sdf_sinc3_chk (
  input wire logic               ref_clk_i,
  input wire logic               reset_i,
  input wire logic               modulator_clock_o,
  input wire sdf_pkg::sdf_word_t sample_o,
  input wire logic               sample_valid_o
);
  import sdf_pkg::*;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  logic [11:0] gap_q;
  logic        seen_q;
  // Cycles since the last word
  always_ff @(posedge ref_clk_i) begin
    gap_q  <= (reset_i || sample_valid_o) ? 12'h000 : gap_q + 12'h001;
    seen_q <= !reset_i && (seen_q || sample_valid_o);
  end
  rst_clk_a: assert property ($fell(reset_i) |-> !modulator_clock_o)
    else $error("clock not low after reset");
  rst_word_a: assert property ($fell(reset_i) |->
    sample_o == 16'h0000 && !sample_valid_o) else $error("word not cleared");
  clk_high_a: assert property ($rose(modulator_clock_o) |->
    modulator_clock_o [*5] ##1 !modulator_clock_o) else $error("bad high");
  clk_low_a: assert property ($fell(modulator_clock_o) |->
    !modulator_clock_o [*5] ##1 modulator_clock_o) else $error("bad low");
  valid_one_a: assert property (sample_valid_o |=> !sample_valid_o)
    else $error("valid too long");
  word_gap_a: assert property (sample_valid_o && seen_q |->
    gap_q == 12'h9FF) else $error("word spacing wrong");
  word_edge_a: assert property (sample_valid_o |->
    $past(modulator_clock_o, 2) && !$past(modulator_clock_o))
    else $error("word not at clock fall");
  word_hold_a: assert property ($changed(sample_o) |-> sample_valid_o)
    else $error("word moved without valid");
endmodule // sdf_sinc3_chk
bind sdf_sinc3_decimator sdf_sinc3_chk u_chk (.ref_clk_i(ref_clk_i),
  .reset_i(reset_i), .modulator_clock_o(modulator_clock_o),
  .sample_o(sample_o), .sample_valid_o(sample_valid_o));

// ==== verif/sdf_sinc3_decimator_tb.sv ====
`timescale 1ns/100ps
module sdf_sinc3_decimator_tb;
  import sdf_pkg::*;
  logic       ref_clk_i = 1'b0;
  logic       reset_i   = 1'b1;
  logic       bit_w, mclk_w, valid_w, b, pm;
  sdf_word_t  sample_w, exp_q[$];
  logic [7:0] dens_q = 8'h80;
  logic [7:0] rnd_q  = 8'h00;
  logic [7:0] dl[5]  = '{8'h80, 8'hD0, 8'h30, 8'hFF, 8'h00};
  logic [31:0] xs    = 32'h79d1;
  sdf_acc_t   a1, a2, a3, c3d, d1, d1d, d2, d2d, d3;
  sdf_cnt_t   cnt;
  int         num_errors = 0;
  int         n_tests    = 0;
  sdf_sinc3_decimator u_dut (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
    .modulator_bitstream_i(bit_w), .modulator_clock_o(mclk_w),
    .sample_o(sample_w), .sample_valid_o(valid_w));
  sdf_mod_model u_mod (.ref_clk_i(ref_clk_i), .modulator_clock_i(mclk_w),
    .dens_i(dens_q), .rnd_i(rnd_q), .modulator_bitstream_o(bit_w));
  function automatic logic [31:0] xsh(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    return v ^ (v << 5);
  endfunction
  task automatic check(input sdf_word_t seen, input sdf_word_t exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t word %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("compares %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial forever #5 ref_clk_i = ~ref_clk_i;
  // Random draw and reference filter stepped on modulator clock edges
  always @(posedge ref_clk_i) begin
    xs = xsh(xs);
    rnd_q <= xs[7:0];
    if (reset_i) begin
      {a1, a2, a3, c3d, d1, d1d, d2, d2d, d3, cnt, b} = '0;
      exp_q.delete();
    end else if (pm && !mclk_w) begin
      cnt = cnt + 8'h01;
      if (cnt == 8'h80) begin
        exp_q.push_back(d3[23:8]);
        d3 = d2 - d2d;
        d2d = d2;
        d2 = d1 - d1d;
        d1d = d1;
        d1 = a3 - c3d;
        c3d = a3;
      end
      b = bit_w;
    end else if (!pm && mclk_w) begin
      a3 = a3 + a2;
      a2 = a2 + a1;
      a1 = a1 + b;
    end
    pm = mclk_w;
    if (!reset_i && valid_w === 1'b1) check(sample_w, exp_q.pop_front());
  end
  // One segment per input density, each from a fresh reset
  initial begin
    repeat (12) @(posedge ref_clk_i);
    foreach (dl[i]) begin
      reset_i <= 1'b1;
      dens_q  <= dl[i];
      repeat (2) @(posedge ref_clk_i);
      reset_i <= 1'b0;
      @(posedge ref_clk_i);
      check(sample_w, 16'h0000);
      repeat (7 * 2560) @(posedge ref_clk_i);
      $display("density %h done", dl[i]);
    end
    test_done();
  end
  // Watchdog about a tenth past the planned run length of some 896 us
  initial begin
    #1000000;
    num_errors++;
    test_done();
  end
endmodule // sdf_sinc3_decimator_tb
